/* File: rtl/scpc_defs.svh */
// constants for the serial and cassette port control block
// What this block does
// RL1: one serial adapter serves cassette and RS423 paths, one path at a time
// RL2: two rate generators, cassette separator, path switch and sine synthesiser
// RL3: cassette receive clock is recovered from the incoming tone signal
// RL4: system clock divided by thirteen forms the intermediate clock
// RL5: intermediate clock is divided to 2400/1200 Hz tones and bit clocks
// RL6: a program-controlled output drives the cassette motor relay
// RL7: carrier detect rises a set delay after high-tone run-in is first seen
// RL8: control bit 6 routes the adapter to cassette or RS423
// RL9: control bit 7 drives the cassette motor relay output directly
// RL10: control bits 0 to 2 select the transmit bit rate
// RL11: control bits 3 to 5 select the RS423 receive bit rate
// RL12: data is sent only while clear-to-send is asserted by the remote end
// RL13: request-to-send is asserted whenever the device can accept data
// RL14: RS423 path has data in, data out, request-to-send and clear-to-send
// RL15: rate codes map to divisor ratios through a configurable lookup
// RL16: on cassette path RS423 output idles at mark and RS423 input is ignored
`ifndef SCPC_DEFS_SVH
`define SCPC_DEFS_SVH
`define SCPC_OFF_CTRL     8'h00
`define SCPC_OFF_STAT     8'h04
`define SCPC_OFF_CDLY     8'h08
`define SCPC_CTRL_RST     8'h00
`define SCPC_CDLY_RST     16'h0960
`define SCPC_STAT_DCD     0
`define SCPC_STAT_CTS     1
`define SCPC_STAT_HITONE  2
`define SCPC_STAT_CDWAIT  3
`define SCPC_STAT_SILENT  4
`define SCPC_SYS_DIV_LAST 4'hc
`define SCPC_TONE_SPLIT   12'h300
`define SCPC_SILENCE      12'h800
`define SCPC_WAVE_MID     4'h8
`endif

/* File: rtl/scpc_pkg.sv */
// types shared by the serial and cassette port control block
package scpc_pkg;
    typedef struct packed {
        logic       motor;
        logic       cas_sel;
        logic [2:0] rx_rate;
        logic [2:0] tx_rate;
    } scpc_ctrl_t;

    typedef struct packed {
        logic txd;
        logic rts;
    } scpc_rs_out_t;

    typedef struct packed {
        logic txclk;
        logic rxclk;
        logic rxd;
        logic cts;
        logic dcd;
    } scpc_adp_out_t;

    typedef enum logic [2:0] {
        CD_IDLE = 3'b001,
        CD_WAIT = 3'b010,
        CD_ON   = 3'b100
    } scpc_cd_state_t;
endpackage : scpc_pkg

/* File: rtl/scpc_top.sv */
// serial adapter routing, rate generators and cassette path
`timescale 1ns/1ps
`include "scpc_defs.svh"
module scpc_top #(
    // half period of each bit clock in intermediate ticks, index is rate code
    parameter logic [7:0][15:0] RATE_HALF = {16'h0200, 16'h0080, 16'h0040, 16'h0020,
                                             16'h0010, 16'h0008, 16'h0004, 16'h0002}
) (
    // system
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // serial adapter side
    input  wire logic                    adp_txd_i,
    input  wire logic                    adp_rts_i,
    output scpc_pkg::scpc_adp_out_t      adp_o,
    // rs423 line
    input  wire logic                    rs_rxd_i,
    input  wire logic                    rs_cts_i,
    output scpc_pkg::scpc_rs_out_t       rs_o,
    // cassette
    input  wire logic                    cas_in_i,
    output logic      [3:0]              cas_wave_o,
    output logic                         cas_motor_o
);
    import scpc_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    function automatic logic [3:0] sine16(input logic [3:0] idx);
        logic [63:0] tbl;
        tbl = 64'h5310135_8bdfffdb8;
        sine16 = tbl[idx*4 +: 4];
    endfunction : sine16

    // register bus
    scpc_ctrl_t  ctrl_q, ctrl_d;
    logic [15:0] cdly_q, cdly_d;
    logic [31:0] rdat_q, rdat_d;
    logic        ack_q,  ack_d;
    logic        req;
    logic [31:0] stat;
    scpc_cd_state_t cd_q, cd_d;
    logic        casrxd_q;
    logic        silent;

    assign req  = wb_cyc_i & wb_stb_i;
    assign stat = {27'h0000000, silent, cd_q == CD_WAIT, casrxd_q, rs_cts_i, adp_o.dcd};

    always_comb
    begin
        ack_d  = req & ~ack_q;
        ctrl_d = ctrl_q;
        cdly_d = cdly_q;
        rdat_d = rdat_q;
        if (req & ~ack_q)
        begin
            case (wb_adr_i)
                `SCPC_OFF_CTRL: rdat_d = {24'h000000, ctrl_q};
                `SCPC_OFF_STAT: rdat_d = stat;
                `SCPC_OFF_CDLY: rdat_d = {16'h0000, cdly_q};
                default:        rdat_d = 32'h00000000;
            endcase
        end
        // a write lands on the edge where the master sees ack
        if (req & ack_q & wb_we_i)
        begin
            if (wb_adr_i == `SCPC_OFF_CTRL && wb_sel_i[0])
                ctrl_d = wb_dat_i[7:0]; // [RL8] [RL9] [RL10] [RL11]
            if (wb_adr_i == `SCPC_OFF_CDLY && wb_sel_i[0])
                cdly_d[7:0] = wb_dat_i[7:0];
            if (wb_adr_i == `SCPC_OFF_CDLY && wb_sel_i[1])
                cdly_d[15:8] = wb_dat_i[15:8];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= `SCPC_CTRL_RST;
            cdly_q <= `SCPC_CDLY_RST;
            rdat_q <= 32'h00000000;
            ack_q  <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            cdly_q <= cdly_d;
            rdat_q <= rdat_d;
            ack_q  <= ack_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // divide by thirteen for the intermediate tick
    logic [3:0] pre_q, pre_d;
    logic       tick_q, tick_d;

    always_comb
    begin
        tick_d = (pre_q == `SCPC_SYS_DIV_LAST); // [RL4]
        pre_d  = tick_d ? 4'h0 : pre_q + 4'h1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pre_q  <= 4'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            pre_q  <= pre_d;
            tick_q <= tick_d;
        end
    end

    // two bit-rate generators, 0 transmit and 1 receive
    logic [1:0] bclk_q;
    genvar g;
    for (g = 0; g < 2; g++)
    begin : g_rate
        logic [15:0] cnt_q, cnt_d;
        logic        clk_d;
        logic [2:0]  code;
        logic [15:0] half;
        assign code = (g == 0) ? ctrl_q.tx_rate : ctrl_q.rx_rate; // [RL10] [RL11]
        assign half = RATE_HALF[code]; // [RL15]
        always_comb
        begin
            cnt_d = cnt_q;
            clk_d = bclk_q[g];
            if (tick_q)
            begin
                // >= keeps a shortened divisor from running the full wrap
                if (cnt_q + 16'h0001 >= half) // [RL2] [RL5]
                begin
                    cnt_d = 16'h0000;
                    clk_d = ~bclk_q[g];
                end
                else
                begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
        end
        always_ff @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                cnt_q     <= 16'h0000;
                bclk_q[g] <= 1'b0;
            end
            else
            begin
                cnt_q     <= cnt_d;
                bclk_q[g] <= clk_d;
            end
        end
    end

    // cassette data/clock separator, measured between rising edges
    logic        cas_q;
    logic [11:0] gap_q, gap_d;
    logic        casrxd_d, rxtgl_q, rxtgl_d, edge_r, hi_ev;

    assign edge_r = cas_in_i & ~cas_q;
    assign silent = (gap_q >= `SCPC_SILENCE);
    assign hi_ev  = edge_r & ~silent & (gap_q < `SCPC_TONE_SPLIT);

    always_comb
    begin
        gap_d    = gap_q;
        casrxd_d = casrxd_q;
        rxtgl_d  = rxtgl_q;
        if (edge_r)
        begin
            gap_d    = 12'h000;
            casrxd_d = hi_ev;
            rxtgl_d  = ~rxtgl_q; // [RL3]
        end
        else if (tick_q && gap_q != 12'hfff)
        begin
            gap_d = gap_q + 12'h001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cas_q    <= 1'b0;
            gap_q    <= 12'hfff;
            casrxd_q <= 1'b1;
            rxtgl_q  <= 1'b0;
        end
        else
        begin
            cas_q    <= cas_in_i;
            gap_q    <= gap_d;
            casrxd_q <= casrxd_d;
            rxtgl_q  <= rxtgl_d;
        end
    end

    // carrier detect: count high-tone cycles of run-in before asserting
    logic [15:0] cd_cnt_q, cd_cnt_d;

    always_comb
    begin
        cd_d     = cd_q;
        cd_cnt_d = cd_cnt_q;
        case (cd_q)
            CD_IDLE:
            begin
                cd_cnt_d = 16'h0000;
                if (ctrl_q.cas_sel && hi_ev)
                begin
                    cd_d = CD_WAIT;
                end
            end
            CD_WAIT:
            begin
                if (!ctrl_q.cas_sel || silent || (edge_r && !hi_ev))
                begin
                    cd_d = CD_IDLE;
                end
                else if (hi_ev)
                begin
                    cd_cnt_d = cd_cnt_q + 16'h0001;
                    if (cd_cnt_q + 16'h0001 >= cdly_q) // [RL7]
                    begin
                        cd_d = CD_ON;
                    end
                end
            end
            CD_ON:
            begin
                // low tone is data, so only silence or leaving the cassette path drops the carrier
                if (!ctrl_q.cas_sel || silent)
                begin
                    cd_d = CD_IDLE;
                end
            end
            default:
            begin
                cd_d = CD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cd_q     <= CD_IDLE;
            cd_cnt_q <= 16'h0000;
        end
        else
        begin
            cd_q     <= cd_d;
            cd_cnt_q <= cd_cnt_d;
        end
    end

    // sine synthesis: mark 2400 Hz, space 1200 Hz, phase kept continuous
    logic [9:0] ph_q, ph_d;
    logic [3:0] wave_d;

    always_comb
    begin
        ph_d = ph_q;
        if (tick_q)
        begin
            ph_d = ph_q + (adp_txd_i ? 10'h002 : 10'h001); // [RL5]
        end
        wave_d = ctrl_q.cas_sel ? sine16(ph_q[9:6]) : `SCPC_WAVE_MID; // [RL2]
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ph_q       <= 10'h000;
            cas_wave_o <= `SCPC_WAVE_MID;
        end
        else
        begin
            ph_q       <= ph_d;
            cas_wave_o <= wave_d;
        end
    end

    // path switch and line outputs
    scpc_rs_out_t  rs_d;
    scpc_adp_out_t adp_d;

    always_comb
    begin
        rs_d.txd    = ctrl_q.cas_sel ? 1'b1 : adp_txd_i; // [RL8] [RL14] [RL16]
        rs_d.rts    = ctrl_q.cas_sel ? 1'b0 : adp_rts_i; // [RL13] [RL14]
        adp_d.rxd   = ctrl_q.cas_sel ? casrxd_q : rs_rxd_i; // [RL1] [RL16]
        adp_d.cts   = ctrl_q.cas_sel ? 1'b1 : rs_cts_i; // [RL12]
        adp_d.dcd   = ctrl_q.cas_sel ? (cd_q == CD_ON) : 1'b1; // [RL7]
        adp_d.txclk = bclk_q[0];
        adp_d.rxclk = ctrl_q.cas_sel ? rxtgl_q : bclk_q[1]; // [RL3] [RL11]
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rs_o        <= 2'b10;
            adp_o       <= 5'b00111;
            cas_motor_o <= 1'b0;
        end
        else
        begin
            rs_o        <= rs_d;
            adp_o       <= adp_d;
            cas_motor_o <= ctrl_q.motor; // [RL6] [RL9]
        end
    end

    // checks
    sequence s_cd_arm;
        (cd_q == CD_IDLE) ##1 (cd_q == CD_WAIT);
    endsequence
    sequence s_ctrl_wr;
        req && ack_q && wb_we_i && wb_adr_i == `SCPC_OFF_CTRL && wb_sel_i[0];
    endsequence

    div_period_a: assert property (tick_q |-> ##13 tick_q) // [RL4]
        else $error("intermediate tick period is not thirteen");
    div_gap_a: assert property (tick_q |=> !tick_q [*8]) // [RL4]
        else $error("intermediate tick repeats too early");
    route_rs_a: assert property (!ctrl_q.cas_sel |=> rs_o.txd == $past(adp_txd_i)) // [RL8]
        else $error("rs423 data out not following adapter");
    mark_idle_a: assert property (ctrl_q.cas_sel |=> rs_o.txd && !rs_o.rts) // [RL16]
        else $error("rs423 output not idle on cassette path");
    // reset value of cts differs from the line's idle level, so skip the release edge
    cts_pass_a: assert property (!rst_i && !ctrl_q.cas_sel |=> // [RL12]
        adp_o.cts == $past(rs_cts_i))
        else $error("clear to send not passed to adapter");
    rts_pass_a: assert property (!ctrl_q.cas_sel |=> rs_o.rts == $past(adp_rts_i)) // [RL13]
        else $error("request to send not passed to line");
    motor_wr_a: assert property (s_ctrl_wr |-> ##2 cas_motor_o == $past(wb_dat_i[7], 2)) // [RL9]
        else $error("motor output does not follow control bit 7");
    cd_arm_a: assert property (s_cd_arm |-> !adp_o.dcd ##1 !adp_o.dcd) // [RL7]
        else $error("carrier asserted without delay");
    cd_count_a: assert property ($rose(cd_q == CD_ON) |-> // [RL7]
        ({1'b0, $past(cd_cnt_q)} + 17'h00001 >= {1'b0, $past(cdly_q)}))
        else $error("carrier asserted before delay count");
    cas_rxclk_a: assert property (ctrl_q.cas_sel && edge_r |=> ##1 adp_o.rxclk == rxtgl_q) // [RL3]
        else $error("cassette receive clock not from tone edges");
    bus_ack_a: assert property (req && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a single cycle");
endmodule : scpc_top

/* File: test/scpc_far_model.sv */
// far-side model: rs423 terminal and cassette tone source
`timescale 1ns/1ps
module scpc_far_model (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // scenario controls, half period in clocks, 0 is silence
    input  wire logic [15:0] cas_half_i,
    input  wire logic        ready_i,
    input  wire logic        data_i,
    // line
    input  wire logic        rts_i,
    output logic             rs_rxd_o,
    output logic             rs_cts_o,
    output logic             cas_o
);
    logic [15:0] cnt_q;
    logic        wrap;

    assign wrap = (cnt_q + 16'h0001) >= cas_half_i;

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q    <= 16'h0000;
            cas_o    <= 1'b0;
            rs_rxd_o <= 1'b1;
            rs_cts_o <= 1'b0;
        end
        else
        begin
            rs_cts_o <= ready_i;
            rs_rxd_o <= rts_i ? data_i : 1'b1;
            cnt_q    <= wrap ? 16'h0000 : cnt_q + 16'h0001;
            if (cas_half_i == 16'h0000)
                cas_o <= 1'b0;
            else if (wrap)
                cas_o <= ~cas_o;
        end
    end
endmodule : scpc_far_model

/* File: test/tb_serial_cassette_port_control.sv */
// self-checking bench for the serial and cassette port control block
`timescale 1ns/1ps
module tb_serial_cassette_port_control;
    import scpc_pkg::*;
    localparam logic [7:0][15:0] HALF = {16'h0200, 16'h0080, 16'h0040, 16'h0020,
                                         16'h0010, 16'h0008, 16'h0004, 16'h0002};
    logic          clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]    wb_adr_i;
    logic [3:0]    wb_sel_i;
    logic [31:0]   wb_dat_i, wb_dat_o, q;
    logic          adp_txd_i, adp_rts_i, rs_rxd_i, rs_cts_i, cas_in_i, cas_motor_o;
    logic          ready, data_b;
    logic [15:0]   cas_half;
    logic [3:0]    cas_wave_o, w;
    scpc_adp_out_t adp_o;
    scpc_rs_out_t  rs_o;
    int            n_fail, n_tests, n_cyc;

    scpc_top #(.RATE_HALF(HALF)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .adp_txd_i(adp_txd_i), .adp_rts_i(adp_rts_i), .adp_o(adp_o), .rs_rxd_i(rs_rxd_i),
        .rs_cts_i(rs_cts_i), .rs_o(rs_o), .cas_in_i(cas_in_i), .cas_wave_o(cas_wave_o),
        .cas_motor_o(cas_motor_o));
    scpc_far_model i_far (.clk_i(clk_i), .rst_i(rst_i), .cas_half_i(cas_half),
        .ready_i(ready), .data_i(data_b), .rts_i(rs_o.rts), .rs_rxd_o(rs_rxd_i),
        .rs_cts_o(rs_cts_i), .cas_o(cas_in_i));

    always #4 clk_i = ~clk_i;

    task end_sim();
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // classic cycle; a hung slave is cut short by the cycle ceiling
    task wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= wr;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    function automatic logic pick(input logic s);
        return s ? adp_o.rxclk : adp_o.txclk;
    endfunction : pick

    // skips two toggles so a rate change in flight does not skew the count
    task meas(input logic s, input logic [31:0] e);
        logic v;
        int   n;
        repeat (2)
        begin
            v = pick(s);
            while (pick(s) === v)
                @(posedge clk_i);
        end
        v = pick(s);
        n = 0;
        while (pick(s) === v)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("bit clock half", e, n);
    endtask : meas

    task t_regs();
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h0, q);
        wb(1'b0, 8'h08, 32'h0);
        chk("cdly reset", 32'h0960, q);
        wb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, q);
        wb_sel_i <= 4'h2;
        wb(1'b1, 8'h08, 32'h1234);
        wb(1'b1, 8'h00, 32'h40);
        wb_sel_i <= 4'hf;
        wb(1'b0, 8'h08, 32'h0);
        chk("cdly lanes", 32'h1260, q);
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl lane", 32'h0, q);
        wb(1'b1, 8'h00, 32'h80);
        repeat (2) @(posedge clk_i);
        chk("motor on", 32'h1, cas_motor_o);
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl back", 32'h80, q);
        wb(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("motor off", 32'h0, cas_motor_o);
    endtask : t_regs

    task t_rs();
        adp_txd_i <= 1'b0;
        adp_rts_i <= 1'b1;
        ready     <= 1'b1;
        data_b    <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("txd", 32'h0, rs_o.txd);
        chk("rts", 32'h1, rs_o.rts);
        chk("cts", 32'h1, adp_o.cts);
        chk("rxd", 32'h0, adp_o.rxd);
        chk("dcd", 32'h1, adp_o.dcd);
        chk("wave mid", 32'h8, cas_wave_o);
        adp_txd_i <= 1'b1;
        adp_rts_i <= 1'b0;
        ready     <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("txd", 32'h1, rs_o.txd);
        chk("rts", 32'h0, rs_o.rts);
        chk("cts", 32'h0, adp_o.cts);
        chk("rxd", 32'h1, adp_o.rxd);
    endtask : t_rs

    task t_cas();
        int n;
        adp_rts_i <= 1'b1;
        wb(1'b1, 8'h08, 32'h3);
        wb(1'b1, 8'h00, 32'h40);
        repeat (4) @(posedge clk_i);
        chk("cas txd", 32'h1, rs_o.txd);
        chk("cas rts", 32'h0, rs_o.rts);
        chk("cas cts", 32'h1, adp_o.cts);
        chk("cas dcd", 32'h0, adp_o.dcd);
        w = cas_wave_o;
        repeat (6656) @(posedge clk_i);
        chk("tone period", w, cas_wave_o);
        cas_half <= 16'd1664;
        repeat (3328) @(posedge clk_i);
        chk("dcd early", 32'h0, adp_o.dcd);
        n = 0;
        while (adp_o.dcd !== 1'b1 && n < 30000)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("dcd late", 32'h1, adp_o.dcd);
        chk("high bit", 32'h1, adp_o.rxd);
        wb(1'b0, 8'h04, 32'h0);
        chk("stat carrier", 32'h5, q);
        cas_half <= 16'd6656;
        repeat (26624) @(posedge clk_i);
        chk("low bit", 32'h0, adp_o.rxd);
        chk("dcd held", 32'h1, adp_o.dcd);
        cas_half <= 16'h0;
        wb(1'b1, 8'h00, 32'h0);
    endtask : t_cas

    task t_rate();
        wb(1'b1, 8'h00, 32'h11);
        meas(1'b0, HALF[1] * 32'd13);
        meas(1'b1, HALF[2] * 32'd13);
        wb(1'b1, 8'h00, 32'h07);
        meas(1'b0, HALF[7] * 32'd13);
    endtask : t_rate

    always @(posedge clk_i)
    begin
        n_cyc++;
        if (n_cyc == 90000)
        begin
            n_fail++;
            end_sim();
        end
    end

    initial
    begin
        clk_i     = 1'b0;
        rst_i     = 1'b1;
        wb_cyc_i  = 1'b0;
        wb_stb_i  = 1'b0;
        wb_we_i   = 1'b0;
        wb_adr_i  = 8'h00;
        wb_sel_i  = 4'hf;
        wb_dat_i  = 32'h0;
        adp_txd_i = 1'b1;
        adp_rts_i = 1'b0;
        ready     = 1'b0;
        data_b    = 1'b1;
        cas_half  = 16'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_rs();
        t_cas();
        t_rate();
        end_sim();
    end
endmodule : tb_serial_cassette_port_control
